/* File: rtl/pmhi_phy_end.sv */
// transceiver end: interface clocks, nibble paths, status and management pin
`timescale 1ns/1ns

// Notes on behaviour
// - management clock up to 25 MHz, asynchronous
// - each end releases data line when other drives; here each drives on its own user enable, controller end wins
// - transmit clock 25 or 2.5 MHz
// - mac holds enable exactly with valid nibbles
// - mac drives transmit nibbles with transmit clock
// - receive clock 25 or 2.5 MHz
// - receive valid marks exactly the data cycles
// - receive error on bad symbol, 100 only
// - receive nibbles driven with receive clock
// - carrier sense high while medium busy
// - half duplex collision on simultaneous activity
// - 10 half duplex heartbeat one microsecond
// - full duplex collision always low
// - continuous 25 MHz reference clock copy
// - reset low one microsecond reinitialises, resamples straps
module pmhi_phy_end #(
  parameter int FIFO_DEPTH = pmhi_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // link to the media access controller
  pmhi_if.phy mii,
  // operating mode and strap
  input wire logic i_speed100,
  input wire logic i_full_duplex,
  input wire logic i_heartbeat_strap,
  // receive stream from the line side
  input wire logic i_rx_valid,
  input wire logic [pmhi_pkg::NIB_W-1:0] i_rx_data,
  input wire logic i_rx_err,
  output logic o_rx_ready,
  input wire logic i_line_active,
  // transmit stream to the line side
  output logic o_tx_valid,
  output logic [pmhi_pkg::NIB_W-1:0] o_tx_data,
  // management data line, user side
  input wire logic i_mdio_bit,
  input wire logic i_mdio_oe,
  output logic o_mdio_sample,
  output logic o_mdio_valid,
  // reference clock copy
  output logic o_reference_clock_output
);
  localparam int NW = pmhi_pkg::NIB_W;
  localparam int SW = NW + 3;  // tx_en, txd, mdc, mdio

  // ==========================================================
  // declarations
  // ==========================================================
  logic [pmhi_pkg::HALF_W-1:0] half_cnt_r;  // cycles left in half
  logic mii_clk_r;         // shared transmit and receive clock
  logic rise_tick;         // clock goes high this edge
  logic fall_tick;         // clock goes low this edge
  logic [SW-1:0] sync1_r;  // first synchroniser stage
  logic [SW-1:0] sync2_r;  // second stage, safe to read
  logic tx_en_s;
  logic [NW-1:0] txd_s;
  logic mdc_s;
  logic mdio_s;
  logic mdc_d_r;           // previous synced management clock
  logic tx_active_r;       // mac is transmitting
  logic [pmhi_pkg::HB_W-1:0] hb_cnt_r;  // heartbeat cycles left
  logic hb_en_r;           // heartbeat strap, caught after reset
  logic strap_done_r;
  logic rx_dv_r;
  logic rx_er_r;
  logic [NW-1:0] rxd_r;
  logic crs_r;
  logic col_r;
  logic mdio_o_r;
  logic mdio_oe_r;
  logic mdio_sample_r;
  logic mdio_valid_r;
  logic tx_valid_r;
  logic [NW-1:0] tx_data_r;
  logic [pmhi_pkg::HALF_W-1:0] ref_cnt_r;
  logic ref_clk_r;
  logic buf_valid;
  logic [NW:0] buf_data;
  logic rx_busy;

  // ==========================================================
  // interface clock divider
  // ==========================================================
  // shared divider
  // rate reloads only at a toggle, so every level lasts a full half
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      half_cnt_r <= '0;
      mii_clk_r <= 1'b0;
    end
    else if (half_cnt_r == '0)
    begin
      mii_clk_r <= ~mii_clk_r;
      half_cnt_r <= i_speed100 ?
        pmhi_pkg::HALF_W'(pmhi_pkg::FAST_HALF - 1) :
        pmhi_pkg::HALF_W'(pmhi_pkg::SLOW_HALF - 1);
    end
    else
    begin
      half_cnt_r <= half_cnt_r - 1'b1;
    end
  end

  assign rise_tick = (half_cnt_r == '0) & ~mii_clk_r;
  assign fall_tick = (half_cnt_r == '0) & mii_clk_r;

  // ==========================================================
  // synchronisers for pins from the other party
  // ==========================================================
  // management clock is asynchronous, so it is resampled here
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {mii.tx_en, mii.txd, mii.mdc, mii.mdio};
      sync2_r <= sync1_r;
    end
  end

  assign {tx_en_s, txd_s, mdc_s, mdio_s} = sync2_r;

  // ==========================================================
  // transmit capture, one nibble per clock rise
  // ==========================================================
  // nibbles sampled once per interface clock period
  // enable low means nothing to send
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tx_active_r <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r <= '0;
    end
    else
    begin
      tx_valid_r <= rise_tick & tx_en_s;
      if (rise_tick)
      begin
        tx_active_r <= tx_en_s;
        tx_data_r <= txd_s;
      end
    end
  end

  // ==========================================================
  // heartbeat strap, caught after reset release
  // ==========================================================
  // strap resampled on every reset
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      hb_en_r <= 1'b0;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      hb_en_r <= i_heartbeat_strap;
      strap_done_r <= 1'b1;
    end
  end

  // ==========================================================
  // heartbeat timer
  // ==========================================================
  // starts as transmission ends
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      hb_cnt_r <= '0;
    end
    else if (rise_tick & tx_active_r & ~tx_en_s & hb_en_r &
             ~i_speed100 & ~i_full_duplex)
    begin
      hb_cnt_r <= pmhi_pkg::HB_W'(pmhi_pkg::HB_CYC);
    end
    else if (hb_cnt_r != '0)
    begin
      hb_cnt_r <= hb_cnt_r - 1'b1;
    end
  end

  // ==========================================================
  // receive buffer, drained one word per clock fall
  // ==========================================================
  // back-pressure reaches the line side through o_rx_ready
  pmhi_fifo #(
    .WIDTH(NW + 1),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_in_valid(i_rx_valid),
    .i_in_data({i_rx_err, i_rx_data}),
    .o_in_ready(o_rx_ready),
    .o_out_valid(buf_valid),
    .o_out_data(buf_data),
    .i_out_ready(fall_tick)
  );

  // ==========================================================
  // receive outputs, changed at the fall so the mac samples at rise
  // ==========================================================
  // nibbles change with the receive clock
  // valid only while a word was taken
  // symbol errors reported in 100 only
  // limitation: a buffer underrun ends the frame early
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rx_dv_r <= 1'b0;
      rx_er_r <= 1'b0;
      rxd_r <= '0;
    end
    else if (fall_tick)
    begin
      rx_dv_r <= buf_valid;
      rx_er_r <= buf_valid & buf_data[NW] & i_speed100;
      rxd_r <= buf_valid ? buf_data[NW-1:0] : '0;
    end
  end

  assign rx_busy = i_line_active | rx_dv_r;

  // ==========================================================
  // carrier sense and collision
  // ==========================================================
  // carrier follows medium activity
  // both directions active in half duplex
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      crs_r <= 1'b0;
      col_r <= 1'b0;
    end
    else
    begin
      crs_r <= rx_busy;
      col_r <= ~i_full_duplex &
               ((tx_active_r & rx_busy) | (hb_cnt_r != '0));
    end
  end

  // ==========================================================
  // management data line
  // ==========================================================
  // drive only when the user claims the line
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mdc_d_r <= 1'b0;
      mdio_o_r <= 1'b1;
      mdio_oe_r <= 1'b0;
      mdio_sample_r <= 1'b1;
      mdio_valid_r <= 1'b0;
    end
    else
    begin
      mdc_d_r <= mdc_s;
      mdio_valid_r <= mdc_s & ~mdc_d_r;
      if (mdc_s & ~mdc_d_r)
      begin
        // sample and update on the same management clock rise
        mdio_sample_r <= mdio_s;
        mdio_o_r <= i_mdio_bit;
        mdio_oe_r <= i_mdio_oe;
      end
    end
  end

  // ==========================================================
  // reference clock copy, free running from reset release
  // ==========================================================
  // continuous copy of the reference
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ref_cnt_r <= '0;
      ref_clk_r <= 1'b0;
    end
    else if (ref_cnt_r == '0)
    begin
      ref_clk_r <= ~ref_clk_r;
      ref_cnt_r <= pmhi_pkg::HALF_W'(pmhi_pkg::REF_HALF - 1);
    end
    else
    begin
      ref_cnt_r <= ref_cnt_r - 1'b1;
    end
  end

  // ==========================================================
  // port drive, all from flip-flops
  // ==========================================================
  assign mii.tx_clk = mii_clk_r;
  assign mii.rx_clk = mii_clk_r;
  assign mii.rx_dv = rx_dv_r;
  assign mii.rx_er = rx_er_r;
  assign mii.rxd = rxd_r;
  assign mii.crs = crs_r;
  assign mii.col = col_r;
  assign mii.mdio_phy_o = mdio_o_r;
  assign mii.mdio_phy_oe = mdio_oe_r;
  assign o_tx_valid = tx_valid_r;
  assign o_tx_data = tx_data_r;
  assign o_mdio_sample = mdio_sample_r;
  assign o_mdio_valid = mdio_valid_r;
  assign o_reference_clock_output = ref_clk_r;
endmodule

/* File: rtl/pmhi_pkg.sv */
// constants shared by both ends of the media independent interface link
package pmhi_pkg;

  // ==========================================================
  // clocking
  // ==========================================================
  localparam int CLK_MHZ = 100;       // rate of i_clk at both ends
  localparam int FAST_MHZ = 25;       // interface clock at 100 Mb/s
  localparam int REF_MHZ = 25;        // reference clock copy
  localparam int SPEED_RATIO = 10;    // 25 MHz over 2.5 MHz
  // half periods in i_clk cycles
  localparam int FAST_HALF = CLK_MHZ / (2 * FAST_MHZ);
  localparam int SLOW_HALF = FAST_HALF * SPEED_RATIO;
  localparam int REF_HALF = CLK_MHZ / (2 * REF_MHZ);
  localparam int HALF_W = $clog2(SLOW_HALF + 1);

  // ==========================================================
  // management clock
  // ==========================================================
  localparam int MDC_MAX_MHZ = 25;
  // least half period meeting the maximum rate, rounded up
  localparam int MDC_MIN_HALF =
    (CLK_MHZ + 2 * MDC_MAX_MHZ - 1) / (2 * MDC_MAX_MHZ);
  localparam int MDC_HALF_DEF = 10;   // 5 MHz by default

  // ==========================================================
  // heartbeat and reset
  // ==========================================================
  localparam int HB_NS = 1000;        // heartbeat pulse length
  localparam int HB_CYC = HB_NS * CLK_MHZ / 1000;
  localparam int HB_W = $clog2(HB_CYC + 1);
  localparam int RESET_MIN_NS = 1000; // least reset low time

  // ==========================================================
  // data path
  // ==========================================================
  localparam int NIB_W = 4;           // nibble width
  localparam int FIFO_DEPTH = 16;     // receive buffer words
  localparam int RXW_W = NIB_W + 1;   // nibble plus symbol error

endpackage

/* File: rtl/pmhi_if.sv */
// interface carrying the nibble data, status and management pins
`timescale 1ns/1ns
interface pmhi_if;
  // transmit group, clock made by the transceiver end
  logic tx_clk;
  logic tx_en;
  logic [pmhi_pkg::NIB_W-1:0] txd;
  // receive group
  logic rx_clk;
  logic rx_dv;
  logic rx_er;
  logic [pmhi_pkg::NIB_W-1:0] rxd;
  logic crs;
  logic col;
  // management pins, data line as output and enable per end
  logic mdc;
  logic mdio_sta_o;
  logic mdio_sta_oe;
  logic mdio_phy_o;
  logic mdio_phy_oe;
  logic mdio;

  // ==========================================================
  // resolved data line, pulled up when nobody drives it
  // ==========================================================
  assign mdio = mdio_sta_oe ? mdio_sta_o :
                (mdio_phy_oe ? mdio_phy_o : 1'b1);

  modport phy (
    output tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col,
    output mdio_phy_o, mdio_phy_oe,
    input tx_en, txd, mdc, mdio
  );

  modport mac (
    input tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col,
    input mdio_phy_o, mdio_phy_oe,
    output tx_en, txd, mdc, mdio_sta_o, mdio_sta_oe,
    input mdio
  );
endinterface

/* File: rtl/pmhi_fifo.sv */
// synchronous first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ns
module pmhi_fifo #(
  parameter int WIDTH = pmhi_pkg::RXW_W,
  parameter int DEPTH = pmhi_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // filling side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // draining side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // elaboration checks
  // ==========================================================
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];  // storage
  logic [AW:0] wr_ptr_r;            // extra bit tells full from empty
  logic [AW:0] rd_ptr_r;
  logic push;
  logic pop;

  // honest flags straight from the pointers
  assign o_in_ready = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_ptr_r != rd_ptr_r;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  // output word comes from the storage flip-flops
  assign o_out_data = mem_r[rd_ptr_r[AW-1:0]];

  // ==========================================================
  // storage write, no reset needed on the data array
  // ==========================================================
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end

  // ==========================================================
  // pointers
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

/* File: rtl/pmhi_mac_end.sv */
// controller end: transmit nibbles, receive capture, management clock
`timescale 1ns/1ns
module pmhi_mac_end #(
  parameter int MDC_HALF = pmhi_pkg::MDC_HALF_DEF
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // link to the transceiver
  pmhi_if.mac mii,
  // transmit stream from the user
  input wire logic i_tx_valid,
  input wire logic [pmhi_pkg::NIB_W-1:0] i_tx_data,
  output logic o_tx_ready,
  // receive stream to the user
  output logic o_rx_valid,
  output logic [pmhi_pkg::NIB_W-1:0] o_rx_data,
  output logic o_rx_err,
  // medium status
  output logic o_crs,
  output logic o_col,
  // management data line, user side
  input wire logic i_mdio_bit,
  input wire logic i_mdio_oe,
  output logic o_mdio_sample,
  output logic o_mdio_valid
);
  localparam int NW = pmhi_pkg::NIB_W;
  localparam int SW = NW + 7;
  localparam int MW = $clog2(MDC_HALF + 1);

  // ==========================================================
  // elaboration checks
  // ==========================================================
  // management clock never faster than its maximum
  if (MDC_HALF < pmhi_pkg::MDC_MIN_HALF)
  begin : g_bad_mdc
    $error("management clock half period too short");
  end

  logic [SW-1:0] sync1_r;  // first synchroniser stage
  logic [SW-1:0] sync2_r;  // second stage, safe to read
  logic tx_clk_s;
  logic rx_clk_s;
  logic rx_dv_s;
  logic rx_er_s;
  logic [NW-1:0] rxd_s;
  logic crs_s;
  logic col_s;
  logic mdio_s;
  logic tx_clk_d_r;
  logic rx_clk_d_r;
  logic tx_rise;
  logic rx_rise;
  logic tx_en_r;
  logic [NW-1:0] txd_r;
  logic rx_valid_r;
  logic rx_err_r;
  logic [NW-1:0] rx_data_r;
  logic crs_r;
  logic col_r;
  logic [MW-1:0] mdc_cnt_r;
  logic mdc_r;
  logic mdio_o_r;
  logic mdio_oe_r;
  logic mdio_sample_r;
  logic mdio_valid_r;

  // ==========================================================
  // synchronisers for pins from the transceiver
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {mii.tx_clk, mii.rx_clk, mii.rx_dv, mii.rx_er,
                  mii.rxd, mii.crs, mii.col, mii.mdio};
      sync2_r <= sync1_r;
    end
  end

  assign {tx_clk_s, rx_clk_s, rx_dv_s, rx_er_s, rxd_s, crs_s, col_s,
          mdio_s} = sync2_r;

  // ==========================================================
  // clock edge finders
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tx_clk_d_r <= 1'b0;
      rx_clk_d_r <= 1'b0;
    end
    else
    begin
      tx_clk_d_r <= tx_clk_s;
      rx_clk_d_r <= rx_clk_s;
    end
  end

  assign tx_rise = tx_clk_s & ~tx_clk_d_r;
  assign rx_rise = rx_clk_s & ~rx_clk_d_r;
  // user word is taken once per transmit clock period
  assign o_tx_ready = tx_rise;

  // ==========================================================
  // transmit drive, updated just after each clock rise
  // ==========================================================
  // enable high only with a valid nibble
  // one nibble per transmit clock period
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      tx_en_r <= 1'b0;
      txd_r <= '0;
    end
    else if (tx_rise)
    begin
      tx_en_r <= i_tx_valid;
      txd_r <= i_tx_valid ? i_tx_data : '0;
    end
  end

  // ==========================================================
  // receive capture at each receive clock rise
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rx_valid_r <= 1'b0;
      rx_err_r <= 1'b0;
      rx_data_r <= '0;
      crs_r <= 1'b0;
      col_r <= 1'b0;
    end
    else
    begin
      rx_valid_r <= rx_rise & rx_dv_s;
      crs_r <= crs_s;
      col_r <= col_s;
      if (rx_rise)
      begin
        // nibbles outside valid cycles carry no meaning
        rx_data_r <= rxd_s;
        rx_err_r <= rx_er_s & rx_dv_s;
      end
    end
  end

  // ==========================================================
  // management clock divider
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mdc_cnt_r <= '0;
      mdc_r <= 1'b0;
    end
    else if (mdc_cnt_r == '0)
    begin
      mdc_r <= ~mdc_r;
      mdc_cnt_r <= MW'(MDC_HALF - 1);
    end
    else
    begin
      mdc_cnt_r <= mdc_cnt_r - 1'b1;
    end
  end

  // ==========================================================
  // management data line
  // ==========================================================
  // drive changes at the fall, released when the user lets go
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mdio_o_r <= 1'b1;
      mdio_oe_r <= 1'b0;
      mdio_sample_r <= 1'b1;
      mdio_valid_r <= 1'b0;
    end
    else
    begin
      mdio_valid_r <= (mdc_cnt_r == '0) & ~mdc_r;
      if ((mdc_cnt_r == '0) & mdc_r)
      begin
        mdio_o_r <= i_mdio_bit;
        mdio_oe_r <= i_mdio_oe;
      end
      if ((mdc_cnt_r == '0) & ~mdc_r)
      begin
        mdio_sample_r <= mdio_s;
      end
    end
  end

  // ==========================================================
  // port drive
  // ==========================================================
  assign mii.tx_en = tx_en_r;
  assign mii.txd = txd_r;
  assign mii.mdc = mdc_r;
  assign mii.mdio_sta_o = mdio_o_r;
  assign mii.mdio_sta_oe = mdio_oe_r;
  assign o_rx_valid = rx_valid_r;
  assign o_rx_data = rx_data_r;
  assign o_rx_err = rx_err_r;
  assign o_crs = crs_r;
  assign o_col = col_r;
  assign o_mdio_sample = mdio_sample_r;
  assign o_mdio_valid = mdio_valid_r;
endmodule

/* File: bench/pmhi_asserts.sv */
// concurrent checks on the link signals between the two ends
`timescale 1ns/1ns
module pmhi_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // link signals
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic [pmhi_pkg::NIB_W-1:0] rxd,
  input wire logic crs,
  input wire logic mdc,
  input wire logic mdio_sta_oe,
  input wire logic mdio_phy_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // receive timing: data moves only on a falling interface clock
  // ==========================================================
  sequence clk_fell;
    $fell(rx_clk);
  endsequence
  a_clk_pair: assert property (rx_clk == tx_clk)
    else $error("receive clock differs");
  a_no_runt: assert property ($changed(tx_clk) |=> $stable(tx_clk))
    else $error("runt clock pulse");
  a_clk_alive: assert property (1 |-> ##[1:20] $changed(tx_clk))
    else $error("transmit clock stalled");
  a_rx_sync: assert property ($changed(rx_dv) |-> clk_fell)
    else $error("valid moved off clock fall");
  a_rxd_idle: assert property (!rx_dv |-> rxd == '0)
    else $error("nibble outside valid");
  a_er_valid: assert property (rx_er |-> rx_dv)
    else $error("error without valid");
  a_crs_follow: assert property ($past(rx_dv) |-> crs)
    else $error("carrier low while receiving");
  // two cycles per half period keeps the clock at or under 25 MHz
  a_mdc_slow: assert property ($changed(mdc) |=> $stable(mdc))
    else $error("management clock too fast");
  a_mdio_single: assert property (!(mdio_sta_oe && mdio_phy_oe))
    else $error("both ends drive data line");
endmodule

/* File: bench/tb_top.sv */
// testbench joining both link ends and checking traffic end to end
`timescale 1ns/1ns
module tb_top;
  // stimulus and observed values
  logic i_clk, i_rstn, spd, fdx, rv, re, la, tv, mbp, mop, mbm, mom;
  logic [3:0] rd, td, ord, otd;
  logic rdy, orv, ore, otv, tr, ps, pv, ms, mv, full, colseen;
  logic rco, rp, oc, ocl;
  logic [7:0] n, r;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [4:0] rxq[$];
  logic [3:0] txq[$];
  pmhi_if mii();
  // strap tied high so heartbeat is enabled
  pmhi_phy_end pmhi_phy_end_i (.i_clk(i_clk), .i_rstn(i_rstn), .mii(mii),
    .i_speed100(spd), .i_full_duplex(fdx), .i_heartbeat_strap(1'b1),
    .i_rx_valid(rv), .i_rx_data(rd), .i_rx_err(re), .o_rx_ready(rdy),
    .i_line_active(la), .o_tx_valid(otv), .o_tx_data(otd),
    .i_mdio_bit(mbp), .i_mdio_oe(mop), .o_mdio_sample(ps),
    .o_mdio_valid(pv), .o_reference_clock_output(rco));
  pmhi_mac_end #(.MDC_HALF(2)) pmhi_mac_end_i (.i_clk(i_clk),
    .i_rstn(i_rstn), .mii(mii), .i_tx_valid(tv), .i_tx_data(td),
    .o_tx_ready(tr), .o_rx_valid(orv), .o_rx_data(ord), .o_rx_err(ore),
    .o_crs(oc), .o_col(ocl), .i_mdio_bit(mbm), .i_mdio_oe(mom),
    .o_mdio_sample(ms), .o_mdio_valid(mv));
  pmhi_asserts pmhi_asserts_i (.i_clk(i_clk), .i_rstn(i_rstn),
    .tx_clk(mii.tx_clk), .rx_clk(mii.rx_clk), .rx_dv(mii.rx_dv),
    .rx_er(mii.rx_er), .rxd(mii.rxd), .crs(mii.crs), .mdc(mii.mdc),
    .mdio_sta_oe(mii.mdio_sta_oe), .mdio_phy_oe(mii.mdio_phy_oe));
  // verdict and end of run
  task automatic conclude();
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // compare one value, report mismatch at once
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // push one receive word, idling valid while the buffer is full
  task automatic push(input logic [3:0] d, input logic e);
    @(negedge i_clk);
    while (rdy !== 1'b1)
    begin
      rv = 0;
      full = 1;
      @(negedge i_clk);
    end
    rv = 1;
    rd = d;
    re = e;
    rxq.push_back({e & spd, d});
    // one edge with valid up, then drop it so no word is pushed twice
    @(negedge i_clk);
    rv = 0;
  endtask
  // offer one nibble, held until the controller end takes it
  task automatic send(input logic [3:0] d);
    @(negedge i_clk);
    tv = 1;
    td = d;
    txq.push_back(d);
    while (tr !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
  endtask
  // drop both strobes and count collision cycles over a window
  task automatic idle(input int k);
    @(negedge i_clk);
    rv = 0;
    tv = 0;
    n = 0;
    r = 0;
    rp = rco;
    repeat (k)
    begin
      @(negedge i_clk);
      n += {7'h00, mii.col === 1'b1};
      r += {7'h00, rco !== rp};
      rp = rco;
    end
  endtask
  initial
  begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  // delivery monitors and hang guard
  // sampled at the fall, away from the edge that launches the outputs
  always @(negedge i_clk)
  begin
    cyc++;
    if (ocl === 1'b1) colseen = 1;
    if (orv === 1'b1) cmp({3'h0, ore, ord}, {3'h0, rxq.pop_front()});
    if (otv === 1'b1) cmp({4'h0, otd}, {4'h0, txq.pop_front()});
    if (cyc == 20000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    {i_rstn, rv, re, la, tv, mop, mom, full, colseen} = '0;
    {spd, mbp, mbm} = 3'h7;
    {fdx, rd, td} = '0;
    repeat (10) @(negedge i_clk);
    i_rstn = 1;
    // fast receive with one bad symbol, then a transmit burst
    for (int i = 0; i < 6; i++) push(4'(i + 9), i == 3);
    for (int i = 0; i < 4; i++) send(4'(4'hC - i));
    idle(100);
    cmp(r, 8'(100 / pmhi_pkg::REF_HALF));
    // slow speed: overfill the buffer, errors must be dropped
    spd = 0;
    for (int i = 0; i < 20; i++) push(4'(i), i[0]);
    cmp({7'h00, full}, 8'h01);
    idle(1000);
    // half duplex heartbeat after a slow frame
    for (int i = 0; i < 3; i++) send(4'h5);
    idle(400);
    cmp(n, 8'(pmhi_pkg::HB_CYC));
    fdx = 1;
    for (int i = 0; i < 3; i++) send(4'h6);
    idle(400);
    cmp(n, 8'h00);
    // fast half duplex with a busy medium
    {fdx, spd, la, colseen} = 4'h6;
    for (int i = 0; i < 4; i++) send(4'h3);
    idle(20);
    cmp({5'h00, colseen, mii.crs, oc}, 8'h07);
    la = 0;
    // management line in both directions and released
    mom = 1;
    mbm = 0;
    repeat (3) do @(negedge i_clk); while (pv !== 1'b1);
    cmp({7'h00, ps}, 8'h00);
    mom = 0;
    repeat (3) do @(negedge i_clk); while (mv !== 1'b1);
    cmp({7'h00, ms}, 8'h01);
    mop = 1;
    mbp = 0;
    repeat (3) do @(negedge i_clk); while (mv !== 1'b1);
    cmp({7'h00, ms}, 8'h00);
    conclude();
  end
endmodule
